//--- hdl/pfrst_core.v
/*
 * Fault recovery and current-sense trigger for a three-channel
 * complementary PWM: fault flags, masks, recovery policy, interrupt,
 * sample/hold trigger and the counter upper byte register.
 * Assumes all inputs synchronous to clock; fault inputs high while
 * asserted; period_start and counter_reload are one-cycle pulses
 * from the counter logic, which also owns modulator_run_enable.
 */
// The plain strobed port was decided locally.
// What this block does
// - Debug recovery bit 0: resume after all faults clear and next period starts.
// - Recovery bit 1: resume after faults clear, flags cleared and a reload.
// - Fault1, comparator, Fault0 bit 0: resume at once when faults clear.
// - Bit 5 set: request interrupt on Fault1 assertion; clear: none.
// - Comparator interrupt enable set: request on comparator fault; clear: none.
// - Fault0 interrupt enable set: request on Fault0 assertion; clear: none.
// - Fault control register writes ignored while the modulator runs.
// - Polarity 0 holds while terms true; 1 holds while terms false.
// - High-side-on enable adds term: all selected high-side outputs active.
// - High-side-off enable adds term: all selected high-side outputs inactive.
// - Low-side-on enable adds term: all selected low-side outputs active.
// - Low-side-off enable adds term: all selected low-side outputs inactive.
// - Per-channel select bits drop unselected channels from every product.
// - Each source sets a sticky flag; software clears it by writing 1.
// - Mask bit 1 stops a source producing a fault; 0 lets it.
`include "pfrst_defines.vh"

module pfrst_core (
    input wire clock,                         // 200 MHz clock
    input wire rst_b,                         // Synchronous reset, low
    input wire [`PFRST_ADDR_W-1:0] reg_addr,  // Register byte address
    input wire [`PFRST_DATA_W-1:0] reg_wdata, // Register write data
    input wire reg_wr,                        // Write strobe
    input wire reg_rd,                        // Read strobe
    output reg [`PFRST_DATA_W-1:0] reg_rdata, // Read data, next cycle
    input wire modulator_run_enable,          // PWM running
    input wire debug_entry,                   // Debug mode entered
    input wire second_fault_in,               // Fault1 asserted
    input wire comparator_fault_in,           // Comparator 0 asserted
    input wire first_fault_in,                // Fault0 asserted
    input wire period_start,                  // New PWM period pulse
    input wire counter_reload,                // Counter reload pulse
    input wire [2:0] upper_output,            // High-side states ch2..0
    input wire [2:0] lower_output,            // Low-side states ch2..0
    output reg outputs_forced,                // Outputs in fault state
    output reg hold_out,                      // Sample/hold hold level
    output reg irq                            // Interrupt request, level
);

    ////////////////////////////////////////////////////////////////////
    // States
    localparam [3:0] ST_RUN = 4'h1;
    localparam [3:0] ST_FAULT = 4'h2;
    localparam [3:0] ST_PERIOD = 4'h4;
    localparam [3:0] ST_SWREC = 4'h8;

    ////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function hit;
        input [`PFRST_ADDR_W-1:0] a;
        input [`PFRST_ADDR_W-1:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Source vector {debug, fault1, comparator, fault0} in byte layout
    function [7:0] src_to_byte;
        input [3:0] s;
        begin
            src_to_byte = 8'h00;
            src_to_byte[`PFRST_ST_DBG] = s[3];
            src_to_byte[`PFRST_ST_F1] = s[2];
            src_to_byte[`PFRST_ST_C0] = s[1];
            src_to_byte[`PFRST_ST_F0] = s[0];
        end
    endfunction

    function [3:0] byte_to_src;
        input [7:0] b;
        begin
            byte_to_src = {b[`PFRST_ST_DBG], b[`PFRST_ST_F1],
                           b[`PFRST_ST_C0], b[`PFRST_ST_F0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] fctl_r;
    reg [7:0] fmask_r;
    reg [7:0] fstat_r;
    reg [7:0] fstat_nxt;
    reg [7:0] shc_r;
    reg [7:0] cnth_r;
    reg [7:0] imask_r;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [3:0] trig_r;
    reg [3:0] trig_nxt;
    reg [7:0] rd_mux;

    wire wr_fctl;
    wire wr_fmask;
    wire wr_fstat;
    wire wr_shc;
    wire wr_cnth;
    wire wr_imask;
    wire [3:0] src_raw;
    wire [3:0] src_active;
    wire [3:0] rst_policy;
    wire [7:0] irq_enable;
    wire [7:0] fault_flags;
    wire flags_clear;
    wire any_active;
    wire hold_raw;
    wire [7:0] irq_cause;

    ////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_fctl = reg_wr & hit(reg_addr, `PFRST_A_FCTL)
                     & ~modulator_run_enable;
    assign wr_fmask = reg_wr & hit(reg_addr, `PFRST_A_FMASK)
                      & ~modulator_run_enable;
    assign wr_fstat = reg_wr & hit(reg_addr, `PFRST_A_FSTAT);
    assign wr_shc = reg_wr & hit(reg_addr, `PFRST_A_SHC);
    assign wr_cnth = reg_wr & hit(reg_addr, `PFRST_A_CNTH);
    assign wr_imask = reg_wr & hit(reg_addr, `PFRST_A_IMASK);

    always @(posedge clock) begin
        if (!rst_b) begin
            fctl_r <= `PFRST_FCTL_RST;
        end else if (wr_fctl) begin
            fctl_r <= reg_wdata & `PFRST_FCTL_BITS;
        end
    end

    // Mask shares the write lock of the control register
    always @(posedge clock) begin
        if (!rst_b) begin
            fmask_r <= `PFRST_FMASK_RST;
        end else if (wr_fmask) begin
            fmask_r <= reg_wdata & `PFRST_FMASK_BITS;
        end
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            shc_r <= `PFRST_SHC_RST;
        end else if (wr_shc) begin
            shc_r <= reg_wdata & `PFRST_SHC_BITS;
        end
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            cnth_r <= `PFRST_CNTH_RST;
        end else if (wr_cnth) begin
            cnth_r <= reg_wdata & `PFRST_CNTH_BITS;
        end
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            imask_r <= `PFRST_IMASK_RST;
        end else if (wr_imask) begin
            imask_r <= reg_wdata & `PFRST_IMASK_BITS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault sources and sticky flags
    assign src_raw = {debug_entry, second_fault_in,
                      comparator_fault_in, first_fault_in};
    // A masked source still sets its flag
    assign src_active = src_raw & ~byte_to_src(fmask_r);
    assign any_active = |src_active;

    // Set wins over a same-cycle write-one clear
    always @* begin
        fstat_nxt = fstat_r;
        if (wr_fstat) begin
            fstat_nxt = fstat_nxt & ~(reg_wdata & `PFRST_FSTAT_BITS);
        end
        fstat_nxt = fstat_nxt | src_to_byte(src_raw);
        if (counter_reload) begin
            fstat_nxt[`PFRST_ST_RLD] = 1'b1;
        end
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            fstat_r <= `PFRST_FSTAT_RST;
        end else begin
            fstat_r <= fstat_nxt;
        end
    end

    assign fault_flags = fstat_r & src_to_byte(4'hF);
    // Reload flag does not hold off software recovery
    assign flags_clear = ~|fault_flags;

    ////////////////////////////////////////////////////////////////////
    // Recovery policy per source {debug, fault1, comparator, fault0}
    assign rst_policy = {fctl_r[`PFRST_FCTL_DBG_RST],
                         fctl_r[`PFRST_FCTL_F1_RST],
                         fctl_r[`PFRST_FCTL_C0_RST],
                         fctl_r[`PFRST_FCTL_F0_RST]};

    // Recovery state machine
    always @* begin
        state_nxt = state_r;
        trig_nxt = trig_r;
        case (state_r)
            ST_RUN: begin
                if (any_active) begin
                    state_nxt = ST_FAULT;
                    trig_nxt = src_active;
                end
            end
            ST_FAULT: begin
                trig_nxt = trig_r | src_active;
                if (!any_active) begin
                    if (|(trig_r & rst_policy)) begin
                        state_nxt = ST_SWREC;
                    end else if (trig_r[3]) begin
                        state_nxt = ST_PERIOD;
                    end else begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_PERIOD: begin
                if (any_active) begin
                    state_nxt = ST_FAULT;
                    trig_nxt = trig_r | src_active;
                end else if (period_start) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_SWREC: begin
                if (any_active) begin
                    state_nxt = ST_FAULT;
                    trig_nxt = trig_r | src_active;
                end else if (flags_clear && counter_reload) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                // Illegal code: treat as a fault from every source
                state_nxt = ST_FAULT;
                trig_nxt = 4'hF;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Triggers gather every source seen during one fault episode
    always @(posedge clock) begin
        if (!rst_b) begin
            trig_r <= 4'h0;
        end else begin
            trig_r <= trig_nxt;
        end
    end

    // Follows the next state, so outputs go off one cycle after a fault
    always @(posedge clock) begin
        if (!rst_b) begin
            outputs_forced <= 1'b0;
        end else begin
            outputs_forced <= (state_nxt != ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt: enables for the fault pins live in the control register
    assign irq_enable = {1'b1, 1'b0, 1'b1, 2'b00,
                         fctl_r[`PFRST_FCTL_F1_INT],
                         fctl_r[`PFRST_FCTL_C0_INT],
                         fctl_r[`PFRST_FCTL_F0_INT]};

    // Next status, so a new event and its interrupt land together
    assign irq_cause = fstat_nxt & imask_r & irq_enable;

    always @(posedge clock) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |irq_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Current-sense hold
    pfrst_hold u_hold (
        .ctl(shc_r),
        .upper_out(upper_output),
        .lower_out(lower_output),
        .hold_raw(hold_raw)
    );

    always @(posedge clock) begin
        if (!rst_b) begin
            hold_out <= 1'b0;
        end else begin
            hold_out <= hold_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path; unmapped and reserved bits read zero
    always @* begin
        case (1'b1)
            hit(reg_addr, `PFRST_A_FCTL): rd_mux = fctl_r;
            hit(reg_addr, `PFRST_A_FMASK): rd_mux = fmask_r;
            hit(reg_addr, `PFRST_A_FSTAT): rd_mux = fstat_r;
            hit(reg_addr, `PFRST_A_SHC): rd_mux = shc_r;
            hit(reg_addr, `PFRST_A_CNTH): rd_mux = cnth_r;
            hit(reg_addr, `PFRST_A_IMASK): rd_mux = imask_r;
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

//--- hdl/pfrst_defines.vh
/*
 * Constants for the fault recovery and current-sense trigger block:
 * register byte addresses, field positions, writable-bit masks, resets.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef PFRST_DEFINES_VH
`define PFRST_DEFINES_VH

// Register port widths
`define PFRST_ADDR_W 12
`define PFRST_DATA_W 8

// Register byte addresses
`define PFRST_A_FMASK 12'hF24
`define PFRST_A_FSTAT 12'hF25
`define PFRST_A_FCTL 12'hF28
`define PFRST_A_SHC 12'hF29
`define PFRST_A_CNTH 12'hF2C
`define PFRST_A_IMASK 12'hF3E

// fault_recovery_control fields
`define PFRST_FCTL_DBG_RST 6
`define PFRST_FCTL_F1_INT 5
`define PFRST_FCTL_F1_RST 4
`define PFRST_FCTL_C0_INT 3
`define PFRST_FCTL_C0_RST 2
`define PFRST_FCTL_F0_INT 1
`define PFRST_FCTL_F0_RST 0

// Fault status, fault mask and interrupt mask fields
`define PFRST_ST_RLD 7
`define PFRST_ST_DBG 5
`define PFRST_ST_F1 2
`define PFRST_ST_C0 1
`define PFRST_ST_F0 0

// current_sense_trigger_control fields
`define PFRST_SHC_POL 7
`define PFRST_SHC_HON 6
`define PFRST_SHC_HOFF 5
`define PFRST_SHC_LON 4
`define PFRST_SHC_LOFF 3
`define PFRST_SHC_SEL_HI 2
`define PFRST_SHC_SEL_LO 0

// Implemented (non-reserved) bits per register
`define PFRST_FCTL_BITS 8'h7F
`define PFRST_FMASK_BITS 8'h27
`define PFRST_FSTAT_BITS 8'hA7
`define PFRST_SHC_BITS 8'hFF
`define PFRST_CNTH_BITS 8'h0F
`define PFRST_IMASK_BITS 8'hA7

// Reset values
`define PFRST_FCTL_RST 8'h00
`define PFRST_FMASK_RST 8'h00
`define PFRST_FSTAT_RST 8'h00
`define PFRST_SHC_RST 8'h00
`define PFRST_CNTH_RST 8'h00
`define PFRST_IMASK_RST 8'h00

`endif

//--- hdl/pfrst_hold.v
/*
 * Sample/hold product terms for the current-sense trigger.
 * Assumes output states are synchronous levels, high meaning active.
 */
`include "pfrst_defines.vh"

module pfrst_hold (
    input wire [7:0] ctl,        // current_sense_trigger_control value
    input wire [2:0] upper_out,  // High-side output states
    input wire [2:0] lower_out,  // Low-side output states
    output wire hold_raw         // Combinational hold level
);

    wire [2:0] sel;
    wire [2:0] hon_ch;
    wire [2:0] hoff_ch;
    wire [2:0] lon_ch;
    wire [2:0] loff_ch;
    wire hon_term;
    wire hoff_term;
    wire lon_term;
    wire loff_term;
    wire any_term;

    assign sel = ctl[`PFRST_SHC_SEL_HI:`PFRST_SHC_SEL_LO];

    ////////////////////////////////////////////////////////////////////
    // Unselected channels drop out of every product
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_chan
            assign hon_ch[i] = ~sel[i] | upper_out[i];
            assign hoff_ch[i] = ~sel[i] | ~upper_out[i];
            assign lon_ch[i] = ~sel[i] | lower_out[i];
            assign loff_ch[i] = ~sel[i] | ~lower_out[i];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    assign hon_term = ctl[`PFRST_SHC_HON] & (&hon_ch);
    assign hoff_term = ctl[`PFRST_SHC_HOFF] & (&hoff_ch);
    assign lon_term = ctl[`PFRST_SHC_LON] & (&lon_ch);
    assign loff_term = ctl[`PFRST_SHC_LOFF] & (&loff_ch);
    assign any_term = hon_term | hoff_term | lon_term | loff_term;
    assign hold_raw = ctl[`PFRST_SHC_POL] ^ any_term;

endmodule

//--- sim/pfrst_core_asserts.sv
/* Port checker for pfrst_core, bound into every instance.
   Assumes one clock and a synchronous active-low reset. */
`include "pfrst_defines.vh"
module pfrst_core_asserts (
    input wire logic clock, // Clock
    input wire logic rst_b, // Reset, low
    input wire logic [11:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic modulator_run_enable, // Running
    input wire logic debug_entry, // Debug fault
    input wire logic second_fault_in, // Fault1
    input wire logic comparator_fault_in, // Comparator
    input wire logic first_fault_in, // Fault0
    input wire logic period_start, // Period pulse
    input wire logic counter_reload, // Reload pulse
    input wire logic [2:0] upper_output, // High side
    input wire logic [2:0] lower_output, // Low side
    input wire logic outputs_forced, // Fault state
    input wire logic hold_out, // Hold level
    input wire logic irq // Interrupt
);
timeunit 1ns;
timeprecision 1ps;
default clocking cb @(posedge clock);
endclocking
default disable iff (!rst_b);
////////////////////////////////////////
logic [7:0] fctl_r, fmask_r, imask_r, shc_r;
wire any_act = |{debug_entry & ~fmask_r[5], second_fault_in & ~fmask_r[2],
    comparator_fault_in & ~fmask_r[1], first_fault_in & ~fmask_r[0]};
function automatic logic hold_f(input logic [7:0] c, input logic [2:0] u, input logic [2:0] l);
    logic [2:0] s;
    s = ~c[2:0];
    hold_f = c[7] ^ (c[6] & &(u | s) | c[5] & &(~u | s) | c[4] & &(l | s) | c[3] & &(~l | s));
endfunction
wire hold_exp = hold_f(shc_r, upper_output, lower_output);
// Shadow copies of the control registers
always @(posedge clock) begin
    if (!rst_b) begin
        fctl_r <= 8'h00;
        fmask_r <= 8'h00;
        imask_r <= 8'h00;
        shc_r <= 8'h00;
    end else if (reg_wr) begin
        if (reg_addr == `PFRST_A_FCTL && !modulator_run_enable) fctl_r <= reg_wdata;
        if (reg_addr == `PFRST_A_FMASK && !modulator_run_enable) fmask_r <= reg_wdata;
        if (reg_addr == `PFRST_A_IMASK) imask_r <= reg_wdata;
        if (reg_addr == `PFRST_A_SHC) shc_r <= reg_wdata;
    end
end
////////////////////////////////////////
a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
a_fctl_read: assert property (reg_rd && reg_addr == `PFRST_A_FCTL |=>
    reg_rdata == ($past(fctl_r) & 8'h7F)) else $error("fault control readback wrong");
a_unmapped_zero: assert property (reg_rd && reg_addr == 12'hF2A |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
a_hold_level: assert property (hold_out == $past(hold_exp))
    else $error("hold level wrong");
a_forced_rise: assert property (any_act |=> outputs_forced)
    else $error("active fault did not force outputs");
a_forced_cause: assert property ($rose(outputs_forced) |-> $past(any_act))
    else $error("outputs forced without active fault");
a_release_clean: assert property ($fell(outputs_forced) |-> !$past(any_act))
    else $error("outputs released while fault active");
a_irq_first: assert property (first_fault_in && fctl_r[1] && imask_r[0] |=> irq)
    else $error("no interrupt on first fault");
a_irq_comp: assert property (comparator_fault_in && fctl_r[3] && imask_r[1] |=> irq)
    else $error("no interrupt on comparator fault");
a_irq_second: assert property (second_fault_in && fctl_r[5] && imask_r[2] |=> irq)
    else $error("no interrupt on second fault");
endmodule
bind pfrst_core pfrst_core_asserts i_pfrst_core_asserts (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .modulator_run_enable(modulator_run_enable),
    .debug_entry(debug_entry), .second_fault_in(second_fault_in),
    .comparator_fault_in(comparator_fault_in), .first_fault_in(first_fault_in),
    .period_start(period_start), .counter_reload(counter_reload),
    .upper_output(upper_output), .lower_output(lower_output),
    .outputs_forced(outputs_forced), .hold_out(hold_out), .irq(irq));

//--- sim/pfrst_stage.sv
/* Power stage model: output states and the first fault pin.
   Assumes demand and trip change just after a rising edge. */
module pfrst_stage (
    input wire logic clock, // Clock
    input wire logic [5:0] demand, // Wanted high, low states
    input wire logic trip, // Overcurrent event
    input wire logic forced, // Fault state from block
    output logic [2:0] upper_output, // High side states
    output logic [2:0] lower_output, // Low side states
    output logic first_fault_in // Fault pin level
);
timeunit 1ns;
timeprecision 1ps;
initial begin
    upper_output = 3'h0;
    lower_output = 3'h0;
    first_fault_in = 1'b0;
end
// Switches off every output while forced
always @(posedge clock) begin
    first_fault_in <= trip;
    upper_output <= forced ? 3'h0 : demand[5:3];
    lower_output <= forced ? 3'h0 : demand[2:0];
end
endmodule

//--- sim/pwm_fault_recovery_and_sense_trigger_tb_top.sv
/* Testbench for pfrst_core: registers, fault recovery, interrupt, hold.
   Assumes the stage model and the bound checker are compiled alongside. */
`include "pfrst_defines.vh"
module pwm_fault_recovery_and_sense_trigger_tb_top;
timeunit 1ns;
timeprecision 1ps;
typedef struct packed {logic [7:0] c; logic [2:0] u; logic [2:0] l; logic h;} pfrst_row_t;
pfrst_row_t rows [11] = '{'{8'h00, 3'h0, 3'h0, 1'h0}, '{8'h80, 3'h0, 3'h0, 1'h1},
    '{8'h47, 3'h7, 3'h0, 1'h1}, '{8'h47, 3'h3, 3'h0, 1'h0}, '{8'h43, 3'h3, 3'h0, 1'h1},
    '{8'h27, 3'h0, 3'h7, 1'h1}, '{8'h27, 3'h1, 3'h0, 1'h0}, '{8'h17, 3'h0, 3'h7, 1'h1},
    '{8'h0F, 3'h7, 3'h0, 1'h1}, '{8'h0F, 3'h7, 3'h4, 1'h0}, '{8'hCF, 3'h7, 3'h0, 1'h0}};
logic [11:0] regs [6] = '{`PFRST_A_FMASK, `PFRST_A_FSTAT, `PFRST_A_FCTL, `PFRST_A_SHC,
    `PFRST_A_CNTH, `PFRST_A_IMASK};
logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
logic dbg = 1'b0, per = 1'b0, rld = 1'b0;
logic [11:0] reg_addr = 12'h000;
logic [7:0] reg_wdata = 8'h00, rd_v;
logic [2:0] src = 3'h0, up, lo;
logic [5:0] demand = 6'h00;
wire [7:0] reg_rdata;
wire f0, forced, hold_out, irq;
int miscompares = 0, checks = 0, cycles = 0;
pfrst_core i_pfrst_core (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .modulator_run_enable(run), .debug_entry(dbg), .second_fault_in(src[2]),
    .comparator_fault_in(src[1]), .first_fault_in(f0), .period_start(per),
    .counter_reload(rld), .upper_output(up), .lower_output(lo),
    .outputs_forced(forced), .hold_out(hold_out), .irq(irq));
pfrst_stage i_pfrst_stage (.clock(clock), .demand(demand), .trip(src[0]), .forced(forced),
    .upper_output(up), .lower_output(lo), .first_fault_in(f0));
initial forever #2.5 clock = ~clock;
always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
        miscompares++;
        close_out();
    end
end
////////////////////////////////////////
task automatic close_out();
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
        miscompares++;
        $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
endtask
task automatic chk_l(input logic g, input logic e);
    checks++;
    if (g !== e) begin
        miscompares++;
        $display("mismatch at %0t: level %h, expected %h", $time, g, e);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
endtask
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
endtask
task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk_b(reg_rdata, e);
endtask
task automatic drive(input logic [2:0] s, input logic d);
    @(posedge clock);
    src <= s;
    dbg <= d;
endtask
task automatic strobe(input logic r);
    @(posedge clock);
    rld <= r;
    per <= ~r;
    @(posedge clock);
    rld <= 1'b0;
    per <= 1'b0;
endtask
////////////////////////////////////////
initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
        wr(`PFRST_A_SHC, rows[i].c);
        @(posedge clock);
        demand <= {rows[i].u, rows[i].l};
        tick(3);
        chk_l(hold_out, rows[i].h);
        rdchk(`PFRST_A_SHC, rows[i].c);
    end
    wr(`PFRST_A_FMASK, 8'hFF);
    wr(`PFRST_A_CNTH, 8'hFF);
    rdchk(`PFRST_A_CNTH, 8'h0F);
    wr(12'hF2A, 8'hFF);
    rdchk(12'hF2A, 8'h00);
    wr(`PFRST_A_FCTL, 8'hFF);
    rdchk(`PFRST_A_FCTL, 8'h7F);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    wr(`PFRST_A_FCTL, 8'h7F);
    @(posedge clock);
    run <= 1'b1;
    wr(`PFRST_A_FCTL, 8'h00);
    rdchk(`PFRST_A_FCTL, 8'h7F);
    @(posedge clock);
    run <= 1'b0;
    wr(`PFRST_A_IMASK, 8'h07);
    for (int i = 0; i < 3; i++) begin
        wr(`PFRST_A_FCTL, 8'h02 << (2 * i));
        drive(3'h1 << i, 1'b0);
        tick(3);
        chk_l(forced, 1'b1);
        chk_l(irq, 1'b1);
        rdchk(`PFRST_A_FSTAT, 8'h01 << i);
        drive(3'h0, 1'b0);
        tick(5);
        chk_l(forced, 1'b0);
        wr(`PFRST_A_FSTAT, 8'hA7);
        rdchk(`PFRST_A_FSTAT, 8'h00);
        chk_l(irq, 1'b0);
        wr(`PFRST_A_FCTL, 8'h00);
        drive(3'h1 << i, 1'b0);
        tick(3);
        drive(3'h0, 1'b0);
        tick(5);
        chk_l(irq, 1'b0);
        wr(`PFRST_A_FSTAT, 8'hA7);
    end
    wr(`PFRST_A_FMASK, 8'h01);
    drive(3'h1, 1'b0);
    tick(4);
    chk_l(forced, 1'b0);
    rdchk(`PFRST_A_FSTAT, 8'h01);
    drive(3'h0, 1'b0);
    wr(`PFRST_A_FSTAT, 8'h01);
    wr(`PFRST_A_FMASK, 8'h00);
    wr(`PFRST_A_FCTL, 8'h01);
    drive(3'h1, 1'b0);
    tick(3);
    drive(3'h0, 1'b0);
    tick(5);
    chk_l(forced, 1'b1);
    strobe(1'b1);
    tick(3);
    chk_l(forced, 1'b1);
    wr(`PFRST_A_FSTAT, 8'hA7);
    strobe(1'b1);
    tick(3);
    chk_l(forced, 1'b0);
    wr(`PFRST_A_FCTL, 8'h00);
    drive(3'h0, 1'b1);
    tick(3);
    drive(3'h0, 1'b0);
    tick(5);
    chk_l(forced, 1'b1);
    strobe(1'b0);
    tick(3);
    chk_l(forced, 1'b0);
    close_out();
end
endmodule
